// >>> rtl/gpio_pkg.sv
package gpio_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NPINS = 8;            // pins in the port
  localparam int NSRC  = 9;            // eight pin sources plus dma
  localparam int AW    = 12;           // byte address width

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFS_DATA_TOP = 12'h3fc; // masked data window
  localparam logic [AW-1:0] OFS_MODE_SET = 12'h400; // mode by pin mask
  localparam logic [AW-1:0] OFS_SELECT   = 12'h404; // pin for readback
  localparam logic [AW-1:0] OFS_PAD_EN   = 12'h408; // pad enables
  localparam logic [AW-1:0] OFS_SENSE    = 12'h40c; // detection type
  localparam logic [AW-1:0] OFS_ADC_TRIG = 12'h410; // adc trigger enables
  localparam logic [AW-1:0] OFS_DMA_TRIG = 12'h414; // dma trigger enables
  localparam logic [AW-1:0] OFS_INT_EN   = 12'h418; // interrupt mask
  localparam logic [AW-1:0] OFS_STATUS   = 12'h41c; // raw status, w1c
  localparam logic [AW-1:0] OFS_MSTATUS  = 12'h420; // masked status
  localparam logic [AW-1:0] OFS_DISCRETE = 12'h424; // discrete lines
  localparam logic [AW-1:0] OFS_LOCK     = 12'h428; // lock key
  localparam logic [AW-1:0] OFS_COMMIT   = 12'h42c; // commit enables

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int MASK_MSB   = 7;       // pin mask in bits 7:0
  localparam int ARG_LSB    = 8;       // argument field above the mask
  localparam int SET_BIT    = 8;       // 1 = set enables, 0 = clear
  localparam int ADDR_MLSB  = 2;       // data mask in address bits 9:2
  localparam int SRC_DMA    = 8;       // dma source bit
  localparam logic [7:0] RST_PINS = 8'h00;
  localparam logic [8:0] RST_SRC  = 9'h000;
  localparam logic [31:0] UNLOCK_KEY = 32'h4c4f434b; // arbitrary value

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    mode_in                 = 2'b00,
    mode_out                = 2'b01,
    peripheral_control_mode = 2'b10
  } pin_mode_t;

  typedef enum logic [2:0] {
    sense_fall = 3'b000,
    sense_rise = 3'b001,
    sense_both = 3'b010,
    sense_low  = 3'b011,
    sense_high = 3'b100
  } sense_t;

endpackage

// >>> rtl/lock_if.sv
// carries lock and commit traffic between the port and its keeper
interface lock_if;
  logic        lock_wr;                  // write to the lock register
  logic        commit_wr;                // write to the commit register
  logic [31:0] wdata;                    // bus write data
  logic        locked;                   // protected pins are locked
  logic [7:0]  config_commit_enable_reg; // pins that may be reconfigured

  modport ctrl   (output lock_wr, commit_wr, wdata,
                  input  locked, config_commit_enable_reg);
  modport keeper (input  lock_wr, commit_wr, wdata,
                  output locked, config_commit_enable_reg);
endinterface

// >>> rtl/lock_keeper.sv
module lock_keeper
  import gpio_pkg::*;
#(
  parameter logic [7:0] PROT_MASK = 8'h0f  // pins behind the lock
)(
  input  wire logic clk,
  input  wire logic rst_b,
  lock_if.keeper    lk
);

  // ----------------------------------------------------------------
  // lock state and commit mask
  // ----------------------------------------------------------------
  wire key_ok = (lk.wdata == UNLOCK_KEY); // correct key written

  // key unlocks, any other value relocks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lk.locked <= 1'b1;
    end else if (lk.lock_wr) begin
      lk.locked <= !key_ok;
    end
  end

  // commit changes only while unlocked; free pins always committed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lk.config_commit_enable_reg <= ~PROT_MASK;
    end else if (lk.commit_wr && !lk.locked) begin
      lk.config_commit_enable_reg <= lk.wdata[7:0] | ~PROT_MASK;
    end
  end

endmodule

// >>> rtl/pin_sense.sv
module pin_sense
  import gpio_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_b,
  input  wire logic   pin_raw,   // asynchronous pad level
  input  wire logic   pad_en,    // pad connected
  input  wire sense_t sense,     // detection type
  output logic        level,     // synchronised, pad-gated level
  output logic        event_hit  // detection condition this cycle
);

  logic s1;    // first synchroniser stage
  logic s2;    // second synchroniser stage
  logic prev;  // level one cycle ago

  // two-stage synchroniser then history
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      prev <= 1'b0;
    end else begin
      s1   <= pin_raw;
      s2   <= s1;
      prev <= level;
    end
  end

  assign level = s2 & pad_en;
  wire rise = level & ~prev;
  wire fall = ~level & prev;

  // detection type selects the condition
  assign event_hit = (sense == sense_rise) ? rise :
                     (sense == sense_fall) ? fall :
                     (sense == sense_both) ? (rise | fall) :
                     (sense == sense_low)  ? ~level :
                     (sense == sense_high) ? level : 1'b0;

endmodule

// >>> rtl/gpio_port.sv
// Behaviour
// RULE1 - eight-bit mask, bit n selects pin n
// RULE2 - each pin input, output or peripheral
// RULE3 - selected pin's mode readable back
// RULE4 - pad enable needed before pin connects
// RULE5 - protected pins need unlock before reconfiguration
// RULE6 - per-pin adc trigger enable, set/clear
// RULE7 - trigger pins still raise their interrupts
// RULE8 - per-pin dma trigger enable, set/clear
// RULE9 - only enabled sources reach interrupt line
// RULE10 - nine sources: eight pins plus dma
// RULE11 - one mask write clears named sources
// RULE12 - summary routed to line zero unless discrete
// RULE13 - raw and masked status both readable
// RULE14 - falling, rising, both, low, high detection
// RULE15 - data access uses address bits as mask
// RULE16 - reset: inputs, triggers off, interrupts cleared
module gpio_port
  import gpio_pkg::*;
#(
  parameter logic [7:0] PROT_MASK = 8'h0f  // pins behind the lock
)(
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic [AW-1:0] addr,
  input  wire logic [31:0]   wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic      [31:0]   rdata,
  input  wire logic [7:0]    pin_in,
  output logic      [7:0]    pin_out,
  output logic      [7:0]    pin_oe,
  input  wire logic [7:0]    periph_out,
  input  wire logic [7:0]    periph_oe,
  output logic      [7:0]    periph_in,
  input  wire logic          dma_done,
  output logic      [7:0]    adc_trig,
  output logic      [7:0]    dma_req,
  output logic               irq,
  output logic      [7:0]    irq_line
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  dir;        // 1 = software output
  logic [7:0]  hw;         // 1 = peripheral control
  logic [7:0]  out_val;    // software output values
  logic [7:0]  pad_en;     // pads connected
  logic [7:0]  adc_en;     // adc trigger enables
  logic [7:0]  dma_en;     // dma trigger enables
  logic [8:0]  int_en;     // interrupt mask
  logic [8:0]  status;     // sticky raw status
  logic        discrete;   // discrete interrupt lines
  logic [2:0]  sel;        // pin chosen for readback
  sense_t      sense [8];  // detection type per pin
  logic [7:0]  level;      // synchronised pin levels
  logic [7:0]  ev;         // detection hits

  lock_if lk ();

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire       is_data  = (addr <= OFS_DATA_TOP);
  wire [7:0] addr_msk = addr[ADDR_MLSB+7:ADDR_MLSB];  // [RULE15]
  wire [7:0] wmask    = wdata[MASK_MSB:0];            // [RULE1]
  wire [7:0] cmask    = wmask & lk.config_commit_enable_reg; // [RULE5]
  wire       set_op   = wdata[SET_BIT];
  wire [1:0] wmode    = wdata[ARG_LSB+1:ARG_LSB];
  wire [2:0] wsense   = wdata[ARG_LSB+2:ARG_LSB];
  wire       data_wr  = wr && is_data;
  wire       mode_wr  = wr && (addr == OFS_MODE_SET);
  wire       sel_wr   = wr && (addr == OFS_SELECT);
  wire       pad_wr   = wr && (addr == OFS_PAD_EN);
  wire       sns_wr   = wr && (addr == OFS_SENSE);
  wire       adc_wr   = wr && (addr == OFS_ADC_TRIG);
  wire       dma_wr   = wr && (addr == OFS_DMA_TRIG);
  wire       en_wr    = wr && (addr == OFS_INT_EN);
  wire       st_wr    = wr && (addr == OFS_STATUS);
  wire       disc_wr  = wr && (addr == OFS_DISCRETE);
  // mode code 3 and detection codes above high are refused
  wire       mode_ok  = (wmode != 2'b11);
  wire       sense_ok = (wsense <= 3'b100);

  // lock and commit writes go to the keeper as plain strobes
  assign lk.lock_wr   = wr && (addr == OFS_LOCK);
  assign lk.commit_wr = wr && (addr == OFS_COMMIT);
  assign lk.wdata     = wdata;

  lock_keeper #(
    .PROT_MASK (PROT_MASK)
  ) u_lock (
    .clk   (clk),
    .rst_b (rst_b),
    .lk    (lk)
  );

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  wire [7:0] next_dir = mode_wr && mode_ok ?
                        (dir & ~cmask) |
                        (cmask & {8{wmode == mode_out}}) : dir; // [RULE2]
  wire [7:0] next_hw  = mode_wr && mode_ok ?
                        (hw & ~cmask) |
                        (cmask & {8{wmode == peripheral_control_mode}}) :
                        hw;                                     // [RULE2]
  wire [7:0] next_out = data_wr ?
                        (out_val & ~addr_msk) |
                        (wdata[7:0] & addr_msk) : out_val;      // [RULE15]
  wire [7:0] next_pad = pad_wr ?
                        (pad_en & ~lk.config_commit_enable_reg) |
                        cmask : pad_en;                         // [RULE5]
  wire [7:0] next_adc = !adc_wr ? adc_en :
                        set_op ? (adc_en | wmask) :
                        (adc_en & ~wmask);                      // [RULE6]
  wire [7:0] next_dma = !dma_wr ? dma_en :
                        set_op ? (dma_en | wmask) :
                        (dma_en & ~wmask);                      // [RULE8]
  wire [8:0] next_int_en = en_wr ? wdata[8:0] : int_en;
  wire [8:0] set_vec  = {dma_done, ev};                         // [RULE10]
  wire [8:0] clr_vec  = st_wr ? wdata[8:0] : 9'h000;            // [RULE11]
  // a new event wins over a clear landing in the same cycle
  wire [8:0] next_status = (status & ~clr_vec) | set_vec;       // [RULE7]
  wire [8:0] next_masked = next_status & next_int_en;           // [RULE9]
  wire       next_disc = disc_wr ? wdata[0] : discrete;
  wire [8:0] masked   = status & int_en;

  // ----------------------------------------------------------------
  // pin sense instances
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      pin_sense u_sense (
        .clk       (clk),
        .rst_b     (rst_b),
        .pin_raw   (pin_in[gi]),
        .pad_en    (pad_en[gi]),         // [RULE4]
        .sense     (sense[gi]),          // [RULE14]
        .level     (level[gi]),
        .event_hit (ev[gi])
      );

      // detection type write, mask selects pins
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          sense[gi] <= sense_fall;
        end else if (sns_wr && sense_ok && wmask[gi]) begin
          sense[gi] <= sense_t'(wsense); // [RULE14]
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // reset leaves every pin a plain input with all sources quiet
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dir      <= RST_PINS;              // [RULE16]
      hw       <= RST_PINS;
      out_val  <= RST_PINS;
      pad_en   <= RST_PINS;
      adc_en   <= RST_PINS;
      dma_en   <= RST_PINS;
      int_en   <= RST_SRC;
      status   <= RST_SRC;
      discrete <= 1'b0;
    end else begin
      dir      <= next_dir;
      hw       <= next_hw;
      out_val  <= next_out;
      pad_en   <= next_pad;
      adc_en   <= next_adc;
      dma_en   <= next_dma;
      int_en   <= next_int_en;
      status   <= next_status;           // [RULE11]
      discrete <= next_disc;
    end
  end

  // readback pin selector
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel <= 3'h0;
    end else if (sel_wr) begin
      sel <= wdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [1:0] sel_mode = {hw[sel], dir[sel] & ~hw[sel]};   // [RULE3]
  // bit 7 discrete flag, bits 6:4 detection type, bits 1:0 mode
  wire [31:0] mode_rd = {24'h0, discrete, sense[sel],
                         2'b00, sel_mode};
  wire [31:0] next_rdata =
    is_data                 ? {24'h0, level & addr_msk} : // [RULE15]
    addr == OFS_MODE_SET    ? {16'h0, hw, dir}          :
    addr == OFS_SELECT      ? mode_rd                   : // [RULE3]
    addr == OFS_PAD_EN      ? {24'h0, pad_en}           :
    addr == OFS_ADC_TRIG    ? {24'h0, adc_en}           :
    addr == OFS_DMA_TRIG    ? {24'h0, dma_en}           :
    addr == OFS_INT_EN      ? {23'h0, int_en}           :
    addr == OFS_STATUS      ? {23'h0, status}           : // [RULE13]
    addr == OFS_MSTATUS     ? {23'h0, masked}           : // [RULE13]
    addr == OFS_DISCRETE    ? {31'h0, discrete}         :
    addr == OFS_LOCK        ? {31'h0, lk.locked}        :
    addr == OFS_COMMIT      ? {24'h0, lk.config_commit_enable_reg} :
    32'h0;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 32'h0;
    end else begin
      rdata <= rd ? next_rdata : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // pins, triggers and interrupt outputs
  // ----------------------------------------------------------------
  // software value unless the pin is under peripheral control
  wire [7:0] next_pin_out = (hw & periph_out) | (~hw & next_out);
  wire [7:0] next_pin_oe  = next_pad &
                            ((hw & periph_oe) | (~hw & next_dir)); // [RULE4]
  // discrete lines: one per pin, dma folded onto line zero
  function automatic logic [7:0] masked_line(input logic [8:0] m);
    masked_line = m[7:0] | {7'h0, m[SRC_DMA]};
  endfunction

  wire [7:0] next_lines   = masked_line(next_masked);       // [RULE12]

  // all outputs registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out   <= 8'h00;
      pin_oe    <= 8'h00;
      periph_in <= 8'h00;
      adc_trig  <= 8'h00;
      dma_req   <= 8'h00;
      irq       <= 1'b0;
      irq_line  <= 8'h00;
    end else begin
      pin_out   <= next_pin_out;
      pin_oe    <= next_pin_oe;
      periph_in <= level;
      adc_trig  <= ev & adc_en;             // [RULE6]
      dma_req   <= ev & dma_en;             // [RULE8]
      irq       <= |next_masked;            // [RULE9]
      irq_line  <= next_disc ? next_lines :
                   {7'h0, |next_masked};    // [RULE12]
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // write data low nine bits, used by the status clear check
  wire [8:0] wlow = wdata[8:0];

  irq_follows_mask_a: assert property ( // [RULE9]
    irq == |(status & int_en))
    else $error("irq does not match masked status");

  quiet_when_off_a: assert property ( // [RULE9]
    (int_en == 9'h000 && !en_wr) |=> !irq)
    else $error("irq raised with all sources disabled");

  set_wins_clear_a: assert property ( // [RULE7]
    (|set_vec) |=> ((status & $past(set_vec)) == $past(set_vec)))
    else $error("event lost from status");

  mask_clear_a: assert property ( // [RULE11]
    (st_wr && (wlow & set_vec) == 9'h000) |=>
    ((status & $past(wlow)) == 9'h000 &&
     (status & ~$past(wlow)) ==
     (($past(status) | $past(set_vec)) & ~$past(wlow))))
    else $error("status clear by mask wrong");

  data_read_mask_a: assert property ( // [RULE15]
    (rd && is_data) |=> ((rdata[7:0] & ~$past(addr_msk)) == 8'h00))
    else $error("unselected pin visible on data read");

  pad_gates_oe_a: assert property ( // [RULE4]
    (pin_oe & ~pad_en) == 8'h00)
    else $error("pin driven with pad disabled");

  locked_pad_hold_a: assert property ( // [RULE5]
    pad_wr |=> (((pad_en ^ $past(pad_en)) &
                 ~$past(lk.config_commit_enable_reg)) == 8'h00))
    else $error("uncommitted pin pad changed");

  summary_route_a: assert property ( // [RULE12]
    (!discrete && !disc_wr) |=>
    (irq_line[7:1] == 7'h00 && irq_line[0] == irq))
    else $error("summary interrupt not on line zero");

  adc_gate_a: assert property ( // [RULE6]
    (adc_trig & ~$past(adc_en)) == 8'h00)
    else $error("adc trigger from disabled pin");

  dma_gate_a: assert property ( // [RULE8]
    (dma_req & ~$past(dma_en)) == 8'h00)
    else $error("dma request from disabled pin");

  trig_keeps_irq_a: assert property ( // [RULE7]
    (|(ev & (adc_en | dma_en) & int_en[7:0]) && !en_wr) |=> irq)
    else $error("trigger pin lost its interrupt");

  locked_mode_hold_a: assert property ( // [RULE5]
    mode_wr |=> ((((dir ^ $past(dir)) | (hw ^ $past(hw))) &
                  ~$past(lk.config_commit_enable_reg)) == 8'h00))
    else $error("uncommitted pin mode changed");

  commit_lock_a: assert property ( // [RULE5]
    (lk.commit_wr && lk.locked) |=>
    $stable(lk.config_commit_enable_reg))
    else $error("commit mask changed while locked");

  masked_read_a: assert property ( // [RULE13]
    (rd && addr == OFS_MSTATUS) |=>
    ((rdata[8:0] & ~$past(int_en)) == 9'h000))
    else $error("masked status shows a disabled source");

  // main scenarios worth seeing
  trig_and_irq_c: cover property (|(ev & adc_en & int_en[7:0]) ##1 irq);
  unlock_c: cover property (lk.locked ##1 !lk.locked);
  discrete_c: cover property (discrete && irq_line[2]);
  dma_src_c: cover property (dma_done ##1 status[SRC_DMA]);
  level_hit_c: cover property (sense[1] == sense_high && ev[1]);

endmodule

// >>> sim/pin_world.sv
// ------------------------------------------------------------------
// pads and on-chip peripherals around the port
// ------------------------------------------------------------------
module pin_world (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,   // port drive value
  input  wire logic [7:0] pin_oe,    // port drive enable
  input  wire logic [7:0] ext_lvl,   // level of the outside source
  input  wire logic [7:0] ext_drv,   // outside source present
  input  wire logic [7:0] per_val,   // peripheral output values
  input  wire logic [7:0] per_en,    // peripheral output enables
  input  wire logic       dma_kick,  // one dma activity pulse
  output logic      [7:0] pin_in,    // resolved wire levels
  output logic      [7:0] periph_out,
  output logic      [7:0] periph_oe,
  output logic            dma_done
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] last;                  // previous wire level

  // undriven wires wander, so a stale value is never trusted
  always_ff @(posedge clk) begin
    last <= pin_in;
  end

  // port drive wins, then the outside source, else the wire drifts
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      pin_in[n] = pin_oe[n] ? pin_out[n] :
                  (ext_drv[n] ? ext_lvl[n] : ~last[n]);
    end
  end

  // peripheral side answers in the same clock domain
  assign periph_out = per_val;
  assign periph_oe  = per_en;
  assign dma_done   = dma_kick;
endmodule

// >>> sim/gpio_port_dir_trigger_irq_tb.sv
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end

module gpio_port_dir_trigger_irq_tb;
  import gpio_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic          clk;
  logic          rst_b;
  logic [AW-1:0] addr;
  logic [31:0]   wdata;
  logic          wr;
  logic          rd;
  logic [31:0]   rdata;
  logic [7:0]    pin_in, pin_out, pin_oe, periph_out, periph_oe, periph_in;
  logic [7:0]    adc_trig, dma_req, irq_line, ext_lvl, per_val, per_en;
  logic          dma_done, dma_kick, irq, seen_adc, seen_dma;
  logic [31:0]   v;                  // last read value
  int            err_total, n_checks;

  typedef struct {logic [11:0] wa; logic [31:0] wd; logic [11:0] ra;
                  logic [31:0] exp;} row_t;
  row_t rows [12] = '{
    '{12'h404, 32'h005, 12'h404, 32'h000},
    '{12'h400, 32'h230, 12'h404, 32'h002},
    '{12'h40c, 32'h420, 12'h404, 32'h042},
    '{12'h424, 32'h001, 12'h404, 32'h0c2},
    '{12'h408, 32'h0ff, 12'h408, 32'h0f0},
    '{12'h410, 32'h1ff, 12'h410, 32'h0ff},
    '{12'h410, 32'h00f, 12'h410, 32'h0f0},
    '{12'h414, 32'h155, 12'h414, 32'h055},
    '{12'h414, 32'h005, 12'h414, 32'h050},
    '{12'h418, 32'h1ff, 12'h418, 32'h1ff},
    '{12'h424, 32'h000, 12'h424, 32'h000},
    '{12'h430, 32'hfff, 12'h430, 32'h000}}; // unmapped place
  logic [11:0] rst_a [12] = '{12'h400, 12'h404, 12'h408, 12'h410, 12'h414,
    12'h418, 12'h41c, 12'h420, 12'h424, 12'h428, 12'h42c, 12'h430};
  logic [31:0] rst_e [12] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 32'h0f0, 0};
  logic [3:0]  sns [5] = '{4'h0, 4'h3, 4'h5, 4'h6, 4'h3}; // code a b hit

  // ----------------------------------------------------------------
  // design and surroundings
  // ----------------------------------------------------------------
  gpio_port #(.PROT_MASK(8'h0f)) i_dut (.clk(clk), .rst_b(rst_b),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
    .dma_done(dma_done), .adc_trig(adc_trig), .dma_req(dma_req),
    .irq(irq), .irq_line(irq_line));

  pin_world i_world (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .ext_lvl(ext_lvl), .ext_drv(8'hff), .per_val(per_val), .per_en(per_en),
    .dma_kick(dma_kick), .pin_in(pin_in), .periph_out(periph_out),
    .periph_oe(periph_oe), .dma_done(dma_done));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [11:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  // wait whole cycles, then settle before looking
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {addr, wdata, wr, rd, dma_kick} = '0;
    {ext_lvl, per_val, per_en} = '0;
    {err_total, n_checks} = '0;
    rst_b = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    // register table rows
    foreach (rows[i]) begin
      bus_wr(rows[i].wa, rows[i].wd);
      bus_rd(rows[i].ra);
      `CHK(v, rows[i].exp)
    end
    // second reset in mid-run restores every default
    @(posedge clk);
    rst_b <= 1'b0;
    tick(2);
    `CHK({pin_oe, irq_line, adc_trig, irq}, 25'h0)
    @(posedge clk);
    rst_b <= 1'b1;
    foreach (rst_a[i]) begin
      bus_rd(rst_a[i]);
      `CHK(v, rst_e[i])
    end
    // unlock, then protected pins accept configuration
    bus_wr(12'h428, UNLOCK_KEY);
    bus_wr(12'h42c, 32'h0ff);
    bus_rd(12'h42c);
    `CHK(v, 32'h0ff)
    bus_wr(12'h408, 32'h0ff);
    bus_rd(12'h408);
    `CHK(v, 32'h0ff)
    // masked data writes change only the addressed pins
    bus_wr(12'h400, 32'h1ff);
    bus_wr(12'h03c, 32'h0a5);
    tick(3);
    `CHK({pin_out, pin_oe}, 16'h05ff)
    bus_wr(12'h3c0, 32'h0ff);
    tick(3);
    `CHK(pin_out, 8'hf5)
    bus_rd(12'h030);
    `CHK(v, 32'h004)
    // peripheral control of the low pins, then a pad switched off
    @(posedge clk);
    per_val <= 8'h0a;
    per_en  <= 8'h0f;
    bus_wr(12'h400, 32'h20f);
    tick(3);
    `CHK({pin_out, pin_oe}, 16'hfaff)
    bus_wr(12'h408, 32'h07f);
    tick(4);
    `CHK({pin_oe, periph_in}, 16'h7f7a)
    // rising edge on a trigger pin still interrupts
    bus_wr(12'h408, 32'h0ff);
    bus_wr(12'h400, 32'h0ff);
    per_en <= 8'h00;
    bus_wr(12'h40c, 32'h104);  // rising detection on pin 2
    bus_wr(12'h410, 32'h104);  // adc trigger on pin 2
    bus_wr(12'h414, 32'h104);  // dma trigger on pin 2
    bus_wr(12'h418, 32'h004);
    bus_wr(12'h41c, 32'h1ff);
    {seen_adc, seen_dma} = '0;
    @(posedge clk);
    ext_lvl[2] <= 1'b1;
    repeat (8) begin
      @(negedge clk);
      seen_adc |= adc_trig[2];
      seen_dma |= dma_req[2];
    end
    `CHK({seen_adc, seen_dma, irq, irq_line}, 11'h701)
    bus_wr(12'h424, 32'h001);
    tick(2);
    `CHK(irq_line, 8'h04)
    @(posedge clk);
    dma_kick <= 1'b1;
    @(posedge clk);
    dma_kick <= 1'b0;
    tick(3);
    bus_rd(12'h41c);
    `CHK(v, 32'h104)
    bus_rd(12'h420);
    `CHK(v, 32'h004)
    bus_wr(12'h418, 32'h000);
    tick(2);
    `CHK({irq, irq_line}, 9'h0)
    bus_wr(12'h41c, 32'h004);
    bus_rd(12'h41c);
    `CHK(v, 32'h100)
    // every detection type on pin 1
    foreach (sns[i]) begin
      @(posedge clk);
      ext_lvl[1] <= sns[i][2];
      tick(4);
      bus_wr(12'h40c, {21'h0, i[2:0], 8'h02});
      tick(4);
      bus_wr(12'h41c, 32'h1ff);
      ext_lvl[1] <= sns[i][1];
      tick(6);
      bus_rd(12'h41c);
      `CHK(v[1], sns[i][0])
    end
    // withdraw the commit, relock, then commit writes and pad writes to protected pins refused
    bus_wr(12'h42c, 32'h000);
    bus_wr(12'h428, 32'h000);
    bus_rd(12'h428);
    `CHK(v, 32'h001)
    bus_wr(12'h42c, 32'h0ff);
    bus_rd(12'h42c);
    `CHK(v, 32'h0f0)
    bus_wr(12'h408, 32'h000);
    bus_rd(12'h408);
    `CHK(v, 32'h00f)
    give_verdict();
  end
endmodule
